// ---- inc/lic_params.svh ----
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH
// How it works
// - Two gain bits pick receive boost: none, 20 dB, 26 dB, 32 dB.
// - Invert bit set flips coded mark inversion polarity on transmit and receive.
// - Receive termination code picks off, 75, 100, 120, 110 ohm; codes 5-7 off.
// - Transmit termination code picks off, 75, 100, 120, 110 ohm; codes 5-7 off.
// - T1: prescaler with source bit 0 means 1.544 base, with 1 means 2.048 base.
// - E1: prescaler codes 0-3 mean 2.048, 4.096, 8.192, 16.384 MHz master clock.
// - Receive level code tracks the line live in 2.5 dB steps; upper nibble zero.
// - Open-circuit flag sets while detected; not in 6312 kHz transmit mode.
// - Current-limit flag sets when limiter would trip; not CMI, 64k or 6312.
// - Jitter FIFO near-limit event sets within 4 bits, clears on read, T1/E1 only.
// - Mask bits 1, 2 enable both-edge interrupts; mask bit 4 enables jitter event.
// - T1 jitter clock comes from prescaled master clock at 0, internal PLL at 1.

// Register indices; byte address is four times the index
`define LIC_IDX_LEVEL    8'h11
`define LIC_IDX_STATUS   8'h14
`define LIC_IDX_MASK     8'h15
`define LIC_IDX_LIVE     8'h16
`define LIC_IDX_JCLK     8'h31
`define LIC_IDX_MONCODE  8'h32
`define LIC_IDX_TERMPS   8'h33
`define LIC_IDX_HI       9
`define LIC_IDX_LO       2

// Field positions
`define LIC_B_TOC        1
`define LIC_B_TCL        2
`define LIC_B_JITTER_FIFO_NEAR_LIMIT       4
`define LIC_B_GAIN       3
`define LIC_B_INV        6
`define LIC_B_LINE_CODE_ENABLE       7
`define LIC_B_JSRC       3
`define LIC_B_RXT        0
`define LIC_B_TXT        3
`define LIC_B_PS         6

// Writable bit masks
`define LIC_STATUS_USED  8'h16
`define LIC_MONCODE_USED 8'hd8
`define LIC_JCLK_USED    8'h08
`define LIC_TERMPS_USED  8'hff

// Reset values
`define LIC_RST_STATUS   8'h00
`define LIC_RST_MASK     8'h00
`define LIC_RST_CTRL     8'h00

// Master clock bases in kHz
`define LIC_T1_BASE_KHZ  16'h0608
`define LIC_E1_BASE_KHZ  16'h0800

// Bus answers
`define LIC_RESP_OKAY    2'h0
`define LIC_RESP_SLVERR  2'h2
`endif

// ---- inc/lic_pkg.sv ----
`include "lic_params.svh"
package lic_pkg;

    typedef enum logic [1:0] {MODE_T1, MODE_E1, MODE_CC64, MODE_6312} lic_mode_t;
    typedef enum logic [2:0] {TERM_OFF, TERM_75, TERM_100, TERM_120, TERM_110} lic_term_t;

    typedef struct packed {
        logic       have_aw;
        logic       have_w;
        logic [7:0] aw_idx;
        logic       aw_hit;
        logic [7:0] wdata;
        logic       wlane;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
    } lic_bus_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] jclk;
        logic [7:0] moncode;
        logic [7:0] termps;
        logic [3:0] lvl_s1;
        logic [3:0] lvl_s2;
        logic [2:0] det_s1;
        logic [2:0] det_s2;
        logic [2:0] det_d;
        logic [1:0] mode_s1;
        logic [1:0] mode_s2;
    } lic_state_t;

    function automatic lic_term_t lic_term_decode(input logic [2:0] code);
        case (code)
            3'h1:    lic_term_decode = TERM_75;
            3'h2:    lic_term_decode = TERM_100;
            3'h3:    lic_term_decode = TERM_120;
            3'h4:    lic_term_decode = TERM_110;
            default: lic_term_decode = TERM_OFF;
        endcase
    endfunction

    function automatic logic lic_reg_hit(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[`LIC_IDX_HI:`LIC_IDX_LO];
        lic_reg_hit = (addr[31:`LIC_IDX_HI+1] == 22'h0) &&
                      (idx == `LIC_IDX_LEVEL || idx == `LIC_IDX_STATUS || idx == `LIC_IDX_MASK ||
                       idx == `LIC_IDX_LIVE || idx == `LIC_IDX_JCLK || idx == `LIC_IDX_MONCODE ||
                       idx == `LIC_IDX_TERMPS);
    endfunction

endpackage

// ---- hw/lic_axil.sv ----
`timescale 1ns/1ns
`default_nettype none
module lic_axil
    import lic_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             wr_stb,
    output logic [7:0]       wr_idx,
    output logic [7:0]       wr_data,
    output logic             wr_lane,
    output logic             rd_stb,
    output logic [7:0]       rd_idx,
    input  wire logic [7:0]  rd_data
);
    lic_bus_t q;
    lic_bus_t next_q;

    assign awready = !q.have_aw && !q.bvalid;
    assign wready  = !q.have_w && !q.bvalid;
    assign arready = !q.rvalid;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign rvalid  = q.rvalid;
    assign rresp   = q.rresp;
    assign rdata   = {24'h0, q.rdata};
    // Write fires only once address and data are both held
    assign wr_stb  = q.have_aw && q.have_w && q.aw_hit;
    assign wr_idx  = q.aw_idx;
    assign wr_data = q.wdata;
    assign wr_lane = q.wlane;
    assign rd_stb  = arvalid && arready && lic_reg_hit(araddr);
    assign rd_idx  = araddr[`LIC_IDX_HI:`LIC_IDX_LO];

    always_comb begin
        next_q = q;
        if (awvalid && awready) begin
            next_q.have_aw = 1'b1;
            next_q.aw_idx  = awaddr[`LIC_IDX_HI:`LIC_IDX_LO];
            next_q.aw_hit  = lic_reg_hit(awaddr);
        end
        if (wvalid && wready) begin
            next_q.have_w = 1'b1;
            next_q.wdata  = wdata[7:0];
            next_q.wlane  = wstrb[0];
        end
        if (q.have_aw && q.have_w) begin
            next_q.have_aw = 1'b0;
            next_q.have_w  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = q.aw_hit ? `LIC_RESP_OKAY : `LIC_RESP_SLVERR;
        end
        if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = lic_reg_hit(araddr) ? `LIC_RESP_OKAY : `LIC_RESP_SLVERR;
            next_q.rdata  = lic_reg_hit(araddr) ? rd_data : 8'h00;
        end else if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    a_bvalid_hold : assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bvalid dropped before bready");

    a_read_answer : assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready |=> rvalid)
        else $error("read address taken without answer next cycle");
endmodule
`default_nettype wire

// ---- hw/lic_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module lic_regs
    import lic_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire lic_mode_t   tx_line_mode,
    input  wire logic        tx_open_det,
    input  wire logic        tx_curr_lim_det,
    input  wire logic        jitter_near_lim_det,
    input  wire logic [3:0]  rx_level_det,
    output logic [1:0]       gain_boost_sel,
    output logic             line_code_enable,
    output logic             line_code_invert,
    output lic_term_t        rx_term,
    output lic_term_t        tx_term,
    output logic [1:0]       prescale_sel,
    output logic             ja_clk_from_pll,
    output logic [15:0]      mclk_expect_khz,
    output logic             irq
);
    lic_state_t q;
    lic_state_t next_q;
    logic       wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic       wr_lane;
    logic       rd_stb;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    lic_mode_t  mode;

    lic_axil u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_stb  (wr_stb),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_lane (wr_lane),
        .rd_stb  (rd_stb),
        .rd_idx  (rd_idx),
        .rd_data (rd_data)
    );

    function automatic logic [15:0] mclk_khz(input lic_mode_t md, input logic src, input logic [1:0] ps);
        logic [15:0] base;
        base = (md == MODE_T1 && !src) ? `LIC_T1_BASE_KHZ : `LIC_E1_BASE_KHZ;
        mclk_khz = base << ps;
    endfunction

    assign mode = lic_mode_t'(q.mode_s2);

    assign gain_boost_sel   = q.moncode[`LIC_B_GAIN+1:`LIC_B_GAIN];
    assign line_code_invert = q.moncode[`LIC_B_INV];
    assign line_code_enable = q.moncode[`LIC_B_LINE_CODE_ENABLE];
    assign rx_term          = lic_term_decode(q.termps[`LIC_B_RXT+2:`LIC_B_RXT]);
    assign tx_term          = lic_term_decode(q.termps[`LIC_B_TXT+2:`LIC_B_TXT]);
    assign prescale_sel     = q.termps[`LIC_B_PS+1:`LIC_B_PS];
    // jitter clock source, only honoured in T1
    assign ja_clk_from_pll  = (mode == MODE_T1) && q.jclk[`LIC_B_JSRC];
    assign mclk_expect_khz  = mclk_khz(mode, q.jclk[`LIC_B_JSRC], prescale_sel);
    assign irq              = |(q.status & q.mask);

    always_comb begin
        set_vec = 8'h00;
        // held while open, plus the falling edge; silent in 6312 kHz
        set_vec[`LIC_B_TOC]  = (mode != MODE_6312) && (q.det_s2[0] || q.det_d[0]);
        // current limit, blocked in line-code and clock modes
        set_vec[`LIC_B_TCL]  = !q.moncode[`LIC_B_LINE_CODE_ENABLE] && (mode == MODE_T1 || mode == MODE_E1) &&
                               (q.det_s2[1] || q.det_d[1]);
        // near-limit event on rising edge, T1/E1 only
        set_vec[`LIC_B_JITTER_FIFO_NEAR_LIMIT] = (mode == MODE_T1 || mode == MODE_E1) && q.det_s2[2] && !q.det_d[2];
    end

    always_comb begin
        clr_vec = 8'h00;
        if (wr_stb && wr_lane && wr_idx == `LIC_IDX_STATUS) begin
            clr_vec = wr_data;
        end
        if (rd_stb && rd_idx == `LIC_IDX_STATUS) begin
            clr_vec[`LIC_B_JITTER_FIFO_NEAR_LIMIT] = 1'b1;
        end
    end

    always_comb begin
        case (rd_idx)
            `LIC_IDX_STATUS:  rd_data = q.status;
            `LIC_IDX_MASK:    rd_data = q.mask;
            `LIC_IDX_JCLK:    rd_data = q.jclk;
            `LIC_IDX_MONCODE: rd_data = q.moncode;
            `LIC_IDX_TERMPS:  rd_data = q.termps;
            `LIC_IDX_LEVEL:   rd_data = {4'h0, q.lvl_s2};
            `LIC_IDX_LIVE:    rd_data = {3'h0, q.det_s2[2], 1'b0, q.det_s2[1:0], 1'b0};
            default:          rd_data = 8'h00;
        endcase
    end

    always_comb begin
        next_q = q;
        // Pin inputs cross two flops before any logic sees them
        next_q.lvl_s1  = rx_level_det;
        next_q.lvl_s2  = q.lvl_s1;
        next_q.det_s1  = {jitter_near_lim_det, tx_curr_lim_det, tx_open_det};
        next_q.det_s2  = q.det_s1;
        next_q.det_d   = q.det_s2;
        next_q.mode_s1 = tx_line_mode;
        next_q.mode_s2 = q.mode_s1;
        // Set beats clear so no event is lost in the clearing cycle
        next_q.status  = ((q.status & ~clr_vec) | set_vec) & `LIC_STATUS_USED;
        if (wr_stb && wr_lane) begin
            case (wr_idx)
                `LIC_IDX_MASK:    next_q.mask    = wr_data & `LIC_STATUS_USED;
                `LIC_IDX_JCLK:    next_q.jclk    = wr_data & `LIC_JCLK_USED;
                // unused line-code bits stored as zero
                `LIC_IDX_MONCODE: next_q.moncode = wr_data & `LIC_MONCODE_USED;
                `LIC_IDX_TERMPS:  next_q.termps  = wr_data & `LIC_TERMPS_USED;
                default:          next_q.mask    = q.mask;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q         <= '0;
            q.status  <= `LIC_RST_STATUS;
            q.mask    <= `LIC_RST_MASK;
            q.jclk    <= `LIC_RST_CTRL;
            q.moncode <= `LIC_RST_CTRL;
            q.termps  <= `LIC_RST_CTRL;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_irq_held : assert property (
        irq && !wr_stb && !rd_stb |=> irq)
        else $error("interrupt dropped before service");

    a_open_sets : assert property (
        q.det_s2[0] && mode != MODE_6312 |=> q.status[`LIC_B_TOC])
        else $error("open circuit not flagged");

    a_open_6312 : assert property (
        mode == MODE_6312 && $past(mode) == MODE_6312 && !$past(q.status[`LIC_B_TOC]) |-> !q.status[`LIC_B_TOC])
        else $error("open circuit flagged in 6312 mode");

    a_jitter_fifo_near_limit_readclr : assert property (
        rd_stb && rd_idx == `LIC_IDX_STATUS && !set_vec[`LIC_B_JITTER_FIFO_NEAR_LIMIT] |=> !q.status[`LIC_B_JITTER_FIFO_NEAR_LIMIT])
        else $error("jitter event survived read");

    a_set_wins : assert property (
        set_vec[`LIC_B_JITTER_FIFO_NEAR_LIMIT] |=> q.status[`LIC_B_JITTER_FIFO_NEAR_LIMIT])
        else $error("jitter event lost");

    a_w1c_clear : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_STATUS && wr_data[`LIC_B_TCL] && !set_vec[`LIC_B_TCL]
        |=> !q.status[`LIC_B_TCL])
        else $error("write one did not clear current limit flag");

    a_unused_zero : assert property (
        ((q.status | q.mask) & ~`LIC_STATUS_USED) == 8'h00)
        else $error("unused status or mask bit set");

    a_level_live : assert property (
        ##2 q.lvl_s2 == $past(rx_level_det, 2))
        else $error("receive level not tracking input");

    a_presc_write : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_TERMPS
        |=> prescale_sel == $past(wr_data[`LIC_B_PS+1:`LIC_B_PS]))
        else $error("prescaler field not written");

    a_ja_t1only : assert property (
        ja_clk_from_pll |-> mode == MODE_T1 && q.jclk[`LIC_B_JSRC])
        else $error("pll jitter clock outside T1");

    a_mclk_e1 : assert property (
        mode == MODE_E1 |-> mclk_expect_khz == (`LIC_E1_BASE_KHZ << prescale_sel))
        else $error("E1 master clock mismatch");

    a_gain_write : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_MONCODE
        |=> gain_boost_sel == $past(wr_data[`LIC_B_GAIN+1:`LIC_B_GAIN]))
        else $error("gain boost field not written");

    a_invert_write : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_MONCODE
        |=> line_code_invert == $past(wr_data[`LIC_B_INV]))
        else $error("line code invert bit not written");

    a_cmi_write : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_MONCODE
        |=> line_code_enable == $past(wr_data[`LIC_B_LINE_CODE_ENABLE]))
        else $error("line code enable bit not written");

    a_rx_term_off : assert property (
        q.termps[`LIC_B_RXT+2] && q.termps[`LIC_B_RXT+1:`LIC_B_RXT] != 2'h0 |-> rx_term == TERM_OFF)
        else $error("receive termination on for spare code");

    a_rx_term_110 : assert property (
        q.termps[`LIC_B_RXT+2:`LIC_B_RXT] == 3'h4 |-> rx_term == TERM_110)
        else $error("receive termination code four wrong");

    a_tx_term_off : assert property (
        q.termps[`LIC_B_TXT+2] && q.termps[`LIC_B_TXT+1:`LIC_B_TXT] != 2'h0 |-> tx_term == TERM_OFF)
        else $error("transmit termination on for spare code");

    a_tx_term_75 : assert property (
        q.termps[`LIC_B_TXT+2:`LIC_B_TXT] == 3'h1 |-> tx_term == TERM_75)
        else $error("transmit termination code one wrong");

    a_mclk_t1 : assert property (
        mode == MODE_T1 && !q.jclk[`LIC_B_JSRC] |-> mclk_expect_khz == (`LIC_T1_BASE_KHZ << q.termps[7:6]))
        else $error("T1 master clock mismatch");

    a_tcl_blocked : assert property (
        (q.moncode[`LIC_B_LINE_CODE_ENABLE] || mode == MODE_CC64 || mode == MODE_6312) && !q.status[`LIC_B_TCL]
        |=> !q.status[`LIC_B_TCL])
        else $error("current limit flagged in blocked mode");

    a_tcl_sets : assert property (
        q.det_s2[1] && !q.moncode[`LIC_B_LINE_CODE_ENABLE] && (mode == MODE_T1 || mode == MODE_E1) |=> q.status[`LIC_B_TCL])
        else $error("current limit not flagged");

    a_jitter_fifo_near_limit_blocked : assert property (
        (mode == MODE_CC64 || mode == MODE_6312) && !q.status[`LIC_B_JITTER_FIFO_NEAR_LIMIT]
        |=> !q.status[`LIC_B_JITTER_FIFO_NEAR_LIMIT])
        else $error("jitter event outside T1 and E1");

    a_mask_write : assert property (
        wr_stb && wr_lane && wr_idx == `LIC_IDX_MASK
        |=> q.mask[`LIC_B_JITTER_FIFO_NEAR_LIMIT] == $past(wr_data[`LIC_B_JITTER_FIFO_NEAR_LIMIT]) && q.mask[`LIC_B_TOC] == $past(wr_data[`LIC_B_TOC]))
        else $error("mask bits not written");

    a_open_falls : assert property (
        $fell(q.det_s2[0]) && mode != MODE_6312 |=> q.status[`LIC_B_TOC])
        else $error("open circuit falling edge not flagged");

    a_ja_pll_t1 : assert property (
        mode == MODE_T1 && q.jclk[`LIC_B_JSRC] |-> ja_clk_from_pll)
        else $error("T1 jitter clock not taken from pll");

    a_level_upper : assert property (
        rd_stb && rd_idx == `LIC_IDX_LEVEL |=> s_axi_rdata[31:4] == 28'h0)
        else $error("receive level upper bits not zero");

    a_ctrl_reset : assert property (
        disable iff (1'b0) !aresetn
        |=> q.moncode == `LIC_RST_CTRL && q.jclk == `LIC_RST_CTRL && q.termps == `LIC_RST_CTRL)
        else $error("control field not cleared by reset");
endmodule
`default_nettype wire

// ---- tb/lic_line_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module lic_line_model
    import lic_pkg::*;
(
    input  wire logic       aclk,
    input  wire lic_mode_t  mode_req,
    input  wire logic [6:0] det_req,
    output lic_mode_t       tx_line_mode,
    output logic            tx_open_det,
    output logic            tx_curr_lim_det,
    output logic            jitter_near_lim_det,
    output logic [3:0]      rx_level_det
);
    // Detectors answer a clock late, so the block never sees a change in the request's own step
    always_ff @(posedge aclk) begin
        tx_line_mode <= mode_req;
        {rx_level_det, jitter_near_lim_det, tx_curr_lim_det, tx_open_det} <= det_req;
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "lic_params.svh"
module tb_top
    import lic_pkg::*;
;
    localparam logic [31:0] A_ST = {22'h0, `LIC_IDX_STATUS, 2'h0};
    localparam logic [31:0] A_MK = {22'h0, `LIC_IDX_MASK, 2'h0};
    localparam logic [31:0] A_LV = {22'h0, `LIC_IDX_LEVEL, 2'h0};
    localparam logic [31:0] A_JC = {22'h0, `LIC_IDX_JCLK, 2'h0};
    localparam logic [31:0] A_MC = {22'h0, `LIC_IDX_MONCODE, 2'h0};
    localparam logic [31:0] A_TP = {22'h0, `LIC_IDX_TERMPS, 2'h0};
    logic        aclk, aresetn, lce, lci, jpll, irq, odet, cdet, jdet;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0]  wstrb, lvl;
    logic [1:0]  bresp, rresp, resp, gain, psel;
    logic [15:0] mclk;
    logic [7:0]  v;
    logic [6:0]  det_req;
    lic_term_t   rxt, txt;
    lic_mode_t   mode_req, mode;
    int          miscompares, total_checks;

    lic_regs lic_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tx_line_mode(mode), .tx_open_det(odet), .tx_curr_lim_det(cdet),
        .jitter_near_lim_det(jdet), .rx_level_det(lvl), .gain_boost_sel(gain),
        .line_code_enable(lce), .line_code_invert(lci), .rx_term(rxt), .tx_term(txt),
        .prescale_sel(psel), .ja_clk_from_pll(jpll), .mclk_expect_khz(mclk), .irq(irq));

    lic_line_model lic_line_model_inst (.aclk(aclk), .mode_req(mode_req), .det_req(det_req),
        .tx_line_mode(mode), .tx_open_det(odet), .tx_curr_lim_det(cdet),
        .jitter_near_lim_det(jdet), .rx_level_det(lvl));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [2:0] tdec(input logic [2:0] c);
        return (c > 3'h4) ? 3'h0 : c;
    endfunction

    // Handshakes are judged at the falling edge, so comb readies never race the driver
    task automatic axw(input logic [31:0] a, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid && bready;
            resp = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [31:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid && rready;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        axr(a);
        chk(rd, {24'h0, e});
    endtask

    // Five edges cover the model's clock plus the block's sync and status latency
    task automatic det(input logic [6:0] d);
        @(posedge aclk);
        det_req <= d;
        repeat (5) @(posedge aclk);
        @(negedge aclk);
    endtask

    task automatic results();
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        results();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, wdata, araddr} = {3{32'h0}};
        wstrb = 4'hf;
        det_req = 7'h0;
        mode_req = MODE_T1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({gain, psel, lce, lci, jpll, irq}, 32'h0);
        chk({rxt, txt}, 32'h0);
        chk(mclk, 32'h608);
        rdc(A_MC, 8'h0);
        rdc(A_TP, 8'h0);
        rdc(A_JC, 8'h0);
        rdc(A_ST, 8'h0);
        rdc(A_MK, 8'h0);
        for (int g = 0; g < 4; g++) begin
            v = {g[0], g[1], 1'b0, g[1:0], 3'h0};
            axw(A_MC, v);
            rdc(A_MC, v);
            @(negedge aclk);
            chk(gain, g[1:0]);
            chk(lce, g[0]);
            chk(lci, g[1]);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge aclk);
            mode_req <= m ? MODE_E1 : MODE_T1;
            repeat (4) @(posedge aclk);
            for (int j = 0; j < 2; j++) begin
                axw(A_JC, j ? 8'h08 : 8'h00);
                for (int c = 0; c < 8; c++) begin
                    axw(A_TP, {c[1:0], 3'(7 - c), c[2:0]});
                    @(negedge aclk);
                    chk(rxt, tdec(c[2:0]));
                    chk(txt, tdec(3'(7 - c)));
                    chk(psel, c[1:0]);
                    chk(mclk, ((m || j) ? 32'h800 : 32'h608) << c[1:0]);
                    chk(mclk, (((m || j) ? 32'h800 : 32'h608) << c[1:0]));
                    chk(jpll, m == 0 && j == 1);
                end
            end
        end
        @(posedge aclk);
        mode_req <= MODE_T1;
        axw(A_MK, 8'h16);
        rdc(A_MK, 8'h16);
        det(7'h02);
        chk(irq, 1'b0);
        rdc(A_ST, 8'h0);
        axw(A_MC, 8'h0);
        rdc(A_ST, 8'h04);
        @(negedge aclk);
        chk(irq, 1'b1);
        det(7'h00);
        rdc(A_ST, 8'h04);
        axw(A_ST, 8'h04);
        rdc(A_ST, 8'h0);
        @(negedge aclk);
        chk(irq, 1'b0);
        @(posedge aclk);
        mode_req <= MODE_6312;
        det(7'h05);
        rdc(A_ST, 8'h0);
        @(posedge aclk);
        mode_req <= MODE_T1;
        det(7'h05);
        rdc(A_ST, 8'h02);
        det(7'h00);
        axw(A_ST, 8'h02);
        rdc(A_ST, 8'h0);
        axw(A_MK, 8'h06);
        det(7'h04);
        chk(irq, 1'b0);
        rdc(A_ST, 8'h10);
        rdc(A_ST, 8'h0);
        det(7'h00);
        axw(A_MK, 8'h16);
        det(7'h04);
        chk(irq, 1'b1);
        axw(A_ST, 8'h10);
        @(negedge aclk);
        chk(irq, 1'b0);
        det(7'h58);
        rdc(A_LV, 8'h0b);
        axw(A_LV, 8'h00);
        rdc(A_LV, 8'h0b);
        axw(32'h100, 8'h01);
        chk(resp, 2'h2);
        axr(32'h100);
        chk({rd[29:0], resp}, 32'h2);
        results();
    end
endmodule
`default_nettype wire
